// ---- hdl/wdg_top.sv ----
`timescale 1ns/1ns
// Functional notes
// - The counter drops by one each time the prescaler completes 16384 clocks.
// - The six low counter bits set the timeout in 64 steps.
// - Armed and stepping 40h to 3Fh starts a reset with the pin low about 30 us.
// - The counter runs even when not armed.
// - Writes do not restart the prescaler.
// - Every reset clears the arm bit.
// - Once the arm bit is set only a reset clears it; zero writes to the arm bit are ignored.
// - Writing arm set with top bit clear forces an immediate reset.
// - HALT while armed resets, subject to the halt option.
// - Control holds arm at bit 7, counter at 6..0, reset value 7Fh.
// - The hardware-watchdog option arms while its option bit is set, across resets.
// - A halt-reset option bit decides if HALT while armed resets.
module wdg_top
   import wdg_pkg::*;
#(
   parameter int DIV = PRESCALE_DIV,
   parameter int PULSE_CYC = RST_PULSE_CYC
) (
   input wire logic clock_in, // Oscillator clock
   input wire logic nrst_in, // Sync reset, low
   input wire logic ce_in, // Clock enable
   input wire logic [3:0] avs_address, // Word address
   input wire logic avs_read, // Read strobe
   input wire logic avs_write, // Write strobe
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic halt_exec_in, // HALT executed pulse
   output logic nrst_pin_out, // Chip reset pin, low
   output logic armed_out // Watchdog armed
);
   logic arm_bit;
   logic [CNT_W-1:0] count_reg;
   logic hw_wdg_reg;
   logic halt_reset_option;
   logic tick;
   logic done_reg;
   logic trig_reg;
   logic forced_reg;
   logic wr_ctrl;
   logic wr_opt;
   logic armed_eff;
   logic [7:0] wdata;

   // ***********************************************
   // Bus slave
   // ***********************************************
   // One wait cycle per access keeps read data registered
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   assign wdata = avs_writedata[7:0];
   assign wr_ctrl = avs_write && !avs_waitrequest && hit(avs_address, WDG_CTRL_ADDR)
      && avs_byteenable[0];
   assign wr_opt = avs_write && !avs_waitrequest && hit(avs_address, WDG_OPT_ADDR)
      && avs_byteenable[0];
   assign armed_eff = arm_bit || hw_wdg_reg;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         avs_waitrequest <= 1'b1;
         done_reg <= 1'b0;
      end else if (ce_in) begin
         done_reg <= (avs_read || avs_write) && avs_waitrequest && !done_reg;
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !done_reg);
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         avs_readdata <= BUS_ZERO;
      end else if (ce_in) begin
         avs_readdata <= BUS_ZERO;
         if (avs_read && avs_waitrequest) begin
            if (hit(avs_address, WDG_CTRL_ADDR)) begin
               avs_readdata[ARM_BIT_POS] <= arm_bit;
               avs_readdata[CNT_W-1:0] <= count_reg;
            end else if (hit(avs_address, WDG_OPT_ADDR)) begin
               avs_readdata[OPT_HWWDG_POS] <= hw_wdg_reg;
               avs_readdata[OPT_HALTRST_POS] <= halt_reset_option;
            end else if (hit(avs_address, WDG_STAT_ADDR)) begin
               avs_readdata[0] <= armed_eff;
               avs_readdata[1] <= forced_reg;
            end
         end
      end
   end

   // ***********************************************
   // Option bits
   // ***********************************************
   // Stand-in for nonvolatile option byte; survives chip reset
   always_ff @(posedge clock_in) begin
      if (ce_in && wr_opt) begin
         hw_wdg_reg <= wdata[OPT_HWWDG_POS];
         halt_reset_option <= wdata[OPT_HALTRST_POS];
      end else if (!nrst_in && $isunknown(hw_wdg_reg)) begin
         hw_wdg_reg <= 1'b0;
         halt_reset_option <= 1'b0;
      end
   end

   // ***********************************************
   // Control register
   // ***********************************************
   wdg_prescaler #(.DIV(DIV)) u_pre (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .tick_out(tick)
   );

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         arm_bit <= CTRL_RESET_VAL[ARM_BIT_POS];
      end else if (ce_in && wr_ctrl && wdata[ARM_BIT_POS]) begin
         // Only set, never cleared by write
         arm_bit <= 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         count_reg <= CTRL_RESET_VAL[CNT_W-1:0];
      end else if (ce_in) begin
         if (wr_ctrl) begin
            // Six low bits set the timeout
            count_reg <= wdata[CNT_W-1:0];
         end else if (tick) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // ***********************************************
   // Reset triggers
   // ***********************************************
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         trig_reg <= 1'b0;
         forced_reg <= 1'b0;
      end else if (ce_in) begin
         trig_reg <= 1'b0;
         // Rollover 40h to 3Fh while armed
         if (armed_eff && tick && !wr_ctrl && count_reg == CNT_ROLL_FROM) begin
            trig_reg <= 1'b1;
         end
         if (wr_ctrl && (wdata[ARM_BIT_POS] || armed_eff) && !wdata[TOP_BIT_POS]) begin
            trig_reg <= 1'b1;
            forced_reg <= 1'b1;
         end
         if (halt_exec_in && armed_eff && halt_reset_option) begin
            trig_reg <= 1'b1;
         end
      end
   end

   wdg_reset_pulse #(.PULSE_CYC(PULSE_CYC)) u_pulse (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .trig_in(trig_reg),
      .nrst_pin_out(nrst_pin_out)
   );

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         armed_out <= 1'b0;
      end else if (ce_in) begin
         armed_out <= armed_eff;
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   // ***********************************************
   // Control checks
   // ***********************************************
   chk_arm_sticky: assert property (@(posedge clock_in) disable iff (!nrst_in)
      $past(arm_bit) && $past(nrst_in) |-> arm_bit)
      else $error("arm bit cleared without reset");

   chk_arm_reset: assert property (@(posedge clock_in)
      !nrst_in |=> !arm_bit)
      else $error("arm bit survived reset");

   chk_ctrl_reset: assert property (@(posedge clock_in)
      !nrst_in |=> count_reg == CTRL_RESET_VAL[CNT_W-1:0] && !armed_out && nrst_pin_out)
      else $error("control not at reset value");

   chk_arm_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && wr_ctrl && wdata[ARM_BIT_POS] |=> arm_bit)
      else $error("arm bit not set by write");

   chk_count_step: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && tick && !wr_ctrl |=> count_reg == $past(count_reg) - 7'h01)
      else $error("counter did not step on tick");

   chk_count_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && !tick && !wr_ctrl |=> $stable(count_reg))
      else $error("counter moved without tick");

   chk_count_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && wr_ctrl |=> count_reg == $past(wdata[6:0]))
      else $error("counter not loaded by write");

   chk_free_run: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && tick && !wr_ctrl && !armed_eff |=> count_reg != $past(count_reg))
      else $error("counter stopped while disarmed");

   chk_armed_out: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in |=> armed_out == $past(armed_eff))
      else $error("armed output does not follow");

   chk_hw_armed: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && hw_wdg_reg |=> armed_out)
      else $error("hardware option not armed");

   chk_opt_halt: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && wr_opt |=> halt_reset_option == $past(wdata[OPT_HALTRST_POS]))
      else $error("halt option not written");

   chk_opt_hw: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && wr_opt |=> hw_wdg_reg == $past(wdata[OPT_HWWDG_POS]))
      else $error("hardware option not written");

   // ***********************************************
   // Reset checks
   // ***********************************************
   // Length of the current low phase on the reset pin
   logic [RST_CNT_W-1:0] low_cnt_reg;
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         low_cnt_reg <= '0;
      end else if (ce_in) begin
         if (nrst_pin_out) begin
            low_cnt_reg <= '0;
         end else begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
         end
      end
   end

   chk_roll_reset: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && armed_eff && tick && !wr_ctrl && count_reg == CNT_ROLL_FROM |=> trig_reg)
      else $error("rollover did not trigger reset");

   chk_soft_reset: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && wr_ctrl && wdata[7] && !wdata[6] |=> trig_reg ##1 !nrst_pin_out)
      else $error("forced reset missing");

   chk_forced_flag: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && wr_ctrl && !wdata[TOP_BIT_POS] && (wdata[ARM_BIT_POS] || armed_eff)
      |=> forced_reg)
      else $error("forced flag not set");

   chk_halt_reset: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && halt_exec_in && armed_eff && halt_reset_option |=> trig_reg)
      else $error("halt reset missing");

   chk_halt_gated: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && halt_exec_in && !halt_reset_option && !tick && !wr_ctrl |=> !trig_reg)
      else $error("halt reset despite option");

   chk_no_disarmed: assert property (@(posedge clock_in) disable iff (!nrst_in)
      trig_reg |-> $past(armed_eff) || $past(wr_ctrl && wdata[7]))
      else $error("reset while disarmed");

   chk_pin_follows: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && trig_reg && nrst_pin_out |=> !nrst_pin_out)
      else $error("reset pin did not fall");

   chk_pulse_len: assert property (@(posedge clock_in) disable iff (!nrst_in)
      $rose(nrst_pin_out) |-> $past(low_cnt_reg) == RST_CNT_W'(PULSE_CYC - 1))
      else $error("reset pulse length wrong");

   // ***********************************************
   // Bus checks
   // ***********************************************
   chk_wait_one: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && (avs_read || avs_write) && avs_waitrequest && !done_reg |=> !avs_waitrequest)
      else $error("no answer after one wait");

   chk_wait_release: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && !avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");

   chk_read_idle: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && !avs_waitrequest |=> avs_readdata == BUS_ZERO)
      else $error("read data not cleared");

   chk_read_ctrl: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && avs_read && avs_waitrequest && hit(avs_address, WDG_CTRL_ADDR)
      |=> avs_readdata[7:0] == {$past(arm_bit), $past(count_reg)})
      else $error("control readback wrong");

   chk_read_status: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && avs_read && avs_waitrequest && hit(avs_address, WDG_STAT_ADDR)
      |=> avs_readdata[1:0] == {$past(forced_reg), $past(armed_eff)})
      else $error("status readback wrong");

   chk_unmapped_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ce_in && avs_read && avs_waitrequest && avs_address > WDG_STAT_ADDR
      |=> avs_readdata == BUS_ZERO)
      else $error("unmapped read not zero");
endmodule

// ---- hdl/wdg_pkg.sv ----
package wdg_pkg;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [3:0] WDG_CTRL_ADDR = 4'h0;
   localparam logic [3:0] WDG_OPT_ADDR = 4'h1;
   localparam logic [3:0] WDG_STAT_ADDR = 4'h2;
   localparam int ARM_BIT_POS = 7;
   localparam int TOP_BIT_POS = 6;
   localparam int CNT_W = 7;
   localparam logic [7:0] CTRL_RESET_VAL = 8'h7F;
   localparam logic [6:0] CNT_ROLL_FROM = 7'h40;
   localparam int OPT_HWWDG_POS = 0;
   localparam int OPT_HALTRST_POS = 1;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int PRESCALE_DIV = 16384;
   localparam int PRESCALE_W = 14;
   localparam int CLK_FREQ_HZ = 25000000;
   localparam int RST_PULSE_NS = 30000;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
   localparam int RST_CNT_W = 12;
   typedef enum logic [1:0] {WDG_IDLE, WDG_PULSE} wdg_rst_state_t;
endpackage

// ---- hdl/wdg_prescaler.sv ----
`timescale 1ns/1ns
module wdg_prescaler
   import wdg_pkg::*;
#(
   parameter int DIV = PRESCALE_DIV
) (
   input wire logic clock_in, // Oscillator clock
   input wire logic nrst_in, // Sync reset, low
   input wire logic ce_in, // Clock enable
   output logic tick_out // Terminal count pulse
);
   logic [PRESCALE_W-1:0] div_reg;
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         div_reg <= '0;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         tick_out <= (div_reg == PRESCALE_W'(DIV - 1));
         if (div_reg == PRESCALE_W'(DIV - 1)) begin
            div_reg <= '0;
         end else begin
            div_reg <= div_reg + 1'b1;
         end
      end
   end
endmodule

// ---- hdl/wdg_reset_pulse.sv ----
`timescale 1ns/1ns
module wdg_reset_pulse
   import wdg_pkg::*;
#(
   parameter int PULSE_CYC = RST_PULSE_CYC
) (
   input wire logic clock_in, // Oscillator clock
   input wire logic nrst_in, // Sync reset, low
   input wire logic ce_in, // Clock enable
   input wire logic trig_in, // Start pulse
   output logic nrst_pin_out // Reset pin, low active
);
   wdg_rst_state_t state_reg;
   logic [RST_CNT_W-1:0] cnt_reg;
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         state_reg <= WDG_IDLE;
         cnt_reg <= '0;
         nrst_pin_out <= 1'b1;
      end else if (ce_in) begin
         case (state_reg)
            WDG_IDLE: begin
               if (trig_in) begin
                  state_reg <= WDG_PULSE;
                  cnt_reg <= RST_CNT_W'(PULSE_CYC - 1);
                  nrst_pin_out <= 1'b0;
               end
            end
            WDG_PULSE: begin
               if (cnt_reg == '0) begin
                  state_reg <= WDG_IDLE;
                  nrst_pin_out <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= WDG_IDLE;
               nrst_pin_out <= 1'b1;
            end
         endcase
      end
   end
endmodule

// ---- sim/wdg_top_tb_top.sv ----
`timescale 1ns/1ns
module wdg_top_tb_top;
   import wdg_pkg::*;
   // Short counts keep the run brief
   localparam int DV = 16;
   localparam int PC = 8;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic halt = 1'b0;
   logic [31:0] rdata;
   logic wait_req;
   logic pin_n;
   logic armed;
   logic [31:0] v;
   int fails = 0;
   int comparisons = 0;
   int n;

   wdg_top #(.DIV(DV), .PULSE_CYC(PC)) DUT (
      .clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'b1), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1),
      .avs_readdata(rdata), .avs_waitrequest(wait_req), .halt_exec_in(halt),
      .nrst_pin_out(pin_n), .armed_out(armed));

   initial begin
      forever #20 clock_in = ~clock_in;
   end

   // *****************************************
   // Bus and check tasks
   // *****************************************
   task automatic give_verdict();
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (ok !== 1'b1) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is seen low
   task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int i;
      @(posedge clock_in);
      addr <= a;
      wdata <= {24'h00_0000, d};
      wr <= is_wr;
      rd <= ~is_wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clock_in);
         if (wait_req === 1'b0) break;
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (i == 20) begin
         fails++;
         give_verdict();
      end
   endtask

   // Counts edges until the reset pin is seen low
   task automatic wait_low(input int max, input bit must, output int c);
      c = 0;
      while (pin_n !== 1'b0 && c < max) begin
         @(posedge clock_in);
         c++;
      end
      if (must && c >= max) begin
         fails++;
         give_verdict();
      end
   endtask

   task automatic do_reset();
      @(posedge clock_in);
      nrst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
   endtask

   task automatic pulse_halt();
      @(posedge clock_in);
      halt <= 1'b1;
      @(posedge clock_in);
      halt <= 1'b0;
   endtask

   // *****************************************
   // Main sequence
   // *****************************************
   initial begin
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      bus(1'b1, WDG_OPT_ADDR, 8'h00, v);
      bus(1'b0, WDG_CTRL_ADDR, 8'h00, v);
      chk(v inside {32'h0000_007F, 32'h0000_007E}, v, 32'h0000_007F);
      chk(armed === 1'b0, armed, 0);
      bus(1'b0, 4'hF, 8'h00, v);
      chk(v === BUS_ZERO, v, BUS_ZERO);
      // Disarmed: counter passes 40h with no reset
      bus(1'b1, WDG_CTRL_ADDR, 8'h41, v);
      wait_low(3 * DV + 4, 1'b0, n);
      chk(n == 3 * DV + 4, n, 3 * DV + 4);
      bus(1'b0, WDG_CTRL_ADDR, 8'h00, v);
      chk(v inside {[32'h0000_003C:32'h0000_003E]}, v, 32'h0000_003D);
      bus(1'b1, WDG_CTRL_ADDR, 8'hC5, v);
      bus(1'b0, WDG_CTRL_ADDR, 8'h00, v);
      chk(v inside {[32'h0000_00C4:32'h0000_00C5]}, v, 32'h0000_00C5);
      chk(armed === 1'b1, armed, 1);
      bus(1'b1, WDG_CTRL_ADDR, 8'h45, v);
      bus(1'b0, WDG_CTRL_ADDR, 8'h00, v);
      chk(v inside {[32'h0000_00C3:32'h0000_00C5]}, v, 32'h0000_00C5);
      // Armed rollover: first step lands anywhere within one prescaler period
      bus(1'b1, WDG_CTRL_ADDR, 8'hC1, v);
      wait_low(2 * DV + 8, 1'b1, n);
      chk(n >= DV && n <= 2 * DV + 4, n, 2 * DV);
      n = 0;
      while (pin_n === 1'b0 && n < 50) begin
         @(posedge clock_in);
         n++;
      end
      chk(n == PC, n, PC);
      do_reset();
      bus(1'b0, WDG_CTRL_ADDR, 8'h00, v);
      chk(v[7] === 1'b0 && armed === 1'b0, v, 32'h0000_007F);
      bus(1'b1, WDG_CTRL_ADDR, 8'hB0, v);
      wait_low(6, 1'b1, n);
      bus(1'b0, WDG_STAT_ADDR, 8'h00, v);
      chk(v === 32'h0000_0003, v, 32'h0000_0003);
      do_reset();
      bus(1'b0, WDG_STAT_ADDR, 8'h00, v);
      chk(v === BUS_ZERO, v, BUS_ZERO);
      bus(1'b1, WDG_OPT_ADDR, 8'h02, v);
      bus(1'b0, WDG_OPT_ADDR, 8'h00, v);
      chk(v === 32'h0000_0002, v, 32'h0000_0002);
      bus(1'b1, WDG_CTRL_ADDR, 8'hFF, v);
      pulse_halt();
      wait_low(6, 1'b1, n);
      do_reset();
      bus(1'b1, WDG_OPT_ADDR, 8'h00, v);
      bus(1'b1, WDG_CTRL_ADDR, 8'hFF, v);
      pulse_halt();
      wait_low(DV, 1'b0, n);
      chk(n == DV, n, DV);
      do_reset();
      bus(1'b1, WDG_OPT_ADDR, 8'h01, v);
      repeat (2) @(posedge clock_in);
      chk(armed === 1'b1, armed, 1);
      wait_low(66 * DV, 1'b1, n);
      do_reset();
      bus(1'b1, WDG_OPT_ADDR, 8'h00, v);
      give_verdict();
   end
endmodule
